// ### shared/fcs_consts.svh
/*
 Register offsets, field positions, command codes and reset values of the
 flash command sequencer. Assumes a 32-bit APB with one aligned word per register.
*/
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// Summary of operation
// [R1] debugger holds reset, sets mass-erase request bit 0, then releases reset
// [R2] hardware clears debug mass-erase request bit when mass erase finishes
// [R3] after mass erase: cpu held, unsecure, security byte programmed to 0xFE
// [R4] decoder accepts codes 0x01-0x04 and 0x06-0x0F
// [R5] erase all and erase block need all three protection disable bits set
// [R6] program or erase before divider write raises access error, no execution
// [R7] invalid command code raises access error, nothing executes
// [R8] flash read while a command runs is invalid and raises illegal access
// [R9] software clears pending access or protection errors before launching
// [R10] software programs only erased longwords, never cumulatively
// [R11] erase-verify all checks whole array; index must be 000
// [R12] failed blank check sets both verify bits; read errors set them singly
// [R13] erase-verify block address from word 0 low byte and word 1
// [R14] erase-verify section: index 010, aligned, valid, not crossing boundary
// [R15] read once fetches phrase 0-7 into words 2-5; index must be 001
// [R16] one-time field is eight phrases, programmable once, never erased
// [R17] software never runs read once from the block holding that field
// [R18] clearing the done flag launches; hardware sets it only at the end
// [R19] program writes up to two longwords; word 0 holds code and address high
// [R20] program needs final index 011 or 101
// [R21] programmed words are read back and verified before completion
// [R22] interrupt request while done flag and its enable are both set
// [R23] parameter buffer and index ignore writes while a command runs

// register byte offsets
`define FCS_A_CLKDIV 8'h00
`define FCS_A_CONFIG 8'h04
`define FCS_A_STATUS 8'h08
`define FCS_A_PROT 8'h0C
`define FCS_A_INDEX 8'h10
`define FCS_A_PARAM 8'h14
`define FCS_A_SEC 8'h18
// status, config and protection bit positions
`define FCS_B_DONE 7
`define FCS_B_ACCESS_ERROR_FLAG 5
`define FCS_B_PVIOL 4
`define FCS_B_IRQEN 7
`define FCS_B_MEREQ 6
`define FCS_B_OPEN 7
`define FCS_B_HDIS 5
`define FCS_B_LDIS 2
// debug access control bits
`define FCS_D_MEREQ 0
`define FCS_D_RESET 3
// reset and security values, configuration longword address
`define FCS_PROT_RST 8'hA4
`define FCS_SEC_SECURED 2'h3
`define FCS_SEC_UNSEC 2'h2
`define FCS_SEC_BYTE 8'hFE
`define FCS_CFG_LW 24'h00040C
// command codes
`define FCS_C_EVALL 8'h01
`define FCS_C_EVBLK 8'h02
`define FCS_C_EVSEC 8'h03
`define FCS_C_RDONCE 8'h04
`define FCS_C_PROG 8'h06
`define FCS_C_PONCE 8'h07
`define FCS_C_ERALL 8'h08
`define FCS_C_ERBLK 8'h09
`define FCS_C_ERSEC 8'h0A
`define FCS_C_UNSEC 8'h0B
`define FCS_C_KEY 8'h0C
`define FCS_C_UMARGIN 8'h0D
`define FCS_C_FMARGIN 8'h0E
`define FCS_C_CONFIG 8'h0F
// parameter index values and limits
`define FCS_IX_0 3'h0
`define FCS_IX_1 3'h1
`define FCS_IX_2 3'h2
`define FCS_IX_3 3'h3
`define FCS_IX_4 3'h4
`define FCS_IX_5 3'h5
`define FCS_PHRASE_MAX 16'h0007
`endif

// ### shared/fcs_pkg.sv
/*
 Types of the flash command sequencer: array operations, sequencer states
 and one array step. Assumes nothing of its surroundings.
*/
package fcs_pkg;
	typedef enum logic [2:0] {OP_BLANK = 3'h0, OP_READ = 3'h1, OP_PROG = 3'h2,
		OP_ERASE = 3'h3, OP_MISC = 3'h4} fcs_op_type;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CHECK = 2'h1, ST_RUN = 2'h3,
		ST_DONE = 2'h2} fcs_state_type;
	typedef struct packed {
		fcs_op_type op;
		logic ifr;
		logic [23:0] addr;
		logic [15:0] len;
		logic [31:0] data;
		logic vfy;
		logic last;
	} fcs_step_type;
endpackage

// ### src/fcs_param_buf.sv
/*
 Indexed command parameter buffer with its index register.
 Assumes writes come from the register slave and fills from the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_param_buf
	import fcs_pkg::*;
#(
	parameter int WORDS = 6
)
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic lock_i,
	input wire logic idx_wr_i,
	input wire logic data_wr_i,
	input wire logic [15:0] wdata_i,
	input wire logic fill_i,
	input wire logic fill_hi_i,
	input wire logic [31:0] fill_data_i,
	output logic [2:0] idx_o,
	output logic [15:0] word_o,
	output logic [WORDS-1:0][15:0] words_o
);
	logic [2:0] fill_at;

	// index register, frozen while a command runs
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			idx_o <= 3'h0;
		else if (idx_wr_i && !lock_i) // [R23]
			idx_o <= wdata_i[2:0];
	end

	// word storage; read-once results land in words 2..5
	assign fill_at = fill_hi_i ? 3'h4 : 3'h2;
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			words_o <= '0;
		else if (fill_i)
		begin
			words_o[fill_at] <= fill_data_i[31:16]; // [R15]
			words_o[fill_at + 3'h1] <= fill_data_i[15:0];
		end
		else if (data_wr_i && !lock_i && idx_o < 3'(WORDS)) // [R23]
			words_o[idx_o] <= wdata_i;
	end

	assign word_o = (idx_o < 3'(WORDS)) ? words_o[idx_o] : 16'h0000;
endmodule
`default_nettype wire

// ### src/fcs_array_port.sv
/*
 Request port toward the flash array: latches one step and holds it until
 the array acknowledges. Assumes the array answers every request once.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_array_port
	import fcs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire fcs_step_type step_i,
	output logic arr_req_o,
	output fcs_op_type arr_op_o,
	output logic arr_ifr_o,
	output logic [23:0] arr_addr_o,
	output logic [15:0] arr_len_o,
	output logic [31:0] arr_wdata_o,
	input wire logic arr_ack_i,
	input wire logic [31:0] arr_rdata_i,
	input wire logic arr_err_i,
	input wire logic arr_uncorr_i,
	input wire logic arr_blank_fail_i,
	output logic done_o,
	output logic [31:0] rdata_o,
	output logic err_o,
	output logic uncorr_o,
	output logic blank_fail_o
);
	fcs_step_type cur;

	// request stands from start until acknowledged
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			arr_req_o <= 1'b0;
			cur <= '0;
		end
		else if (start_i)
		begin
			arr_req_o <= 1'b1;
			cur <= step_i;
		end
		else if (arr_ack_i)
			arr_req_o <= 1'b0;
	end

	// result capture, done pulses one cycle after the acknowledge
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			done_o <= 1'b0;
			rdata_o <= 32'h0;
			{err_o, uncorr_o, blank_fail_o} <= 3'h0;
		end
		else
		begin
			done_o <= arr_req_o && arr_ack_i;
			if (arr_req_o && arr_ack_i)
			begin
				rdata_o <= arr_rdata_i;
				{err_o, uncorr_o, blank_fail_o} <= {arr_err_i, arr_uncorr_i, arr_blank_fail_i};
			end
		end
	end

	assign arr_op_o = cur.op;
	assign arr_ifr_o = cur.ifr;
	assign arr_addr_o = cur.addr;
	assign arr_len_o = cur.len;
	assign arr_wdata_o = cur.data;
endmodule
`default_nettype wire

// ### src/fcs_sequencer.sv
/*
 Flash command sequencer: APB registers, command checks, step sequencing,
 status flags and the debugger mass erase. Assumes an external flash array
 that acknowledges each request, and chip logic that supplies the mode mask.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.svh"
module fcs_sequencer
	import fcs_pkg::*;
#(
	parameter logic [23:0] FLASH_BYTES = 24'h010000,
	parameter logic [23:0] SECTOR_BYTES = 24'h000200
)
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic dbg_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic dbg_wr_i,
	input wire logic [3:0] dbg_wdata_i,
	output logic [3:0] dbg_ctrl_o,
	input wire logic [15:0] cmd_permit_i,
	input wire logic flash_rd_i,
	output logic illegal_access_o,
	output logic cpu_hold_o,
	output logic irq_o,
	output logic arr_req_o,
	output fcs_op_type arr_op_o,
	output logic arr_ifr_o,
	output logic [23:0] arr_addr_o,
	output logic [15:0] arr_len_o,
	output logic [31:0] arr_wdata_o,
	input wire logic arr_ack_i,
	input wire logic [31:0] arr_rdata_i,
	input wire logic arr_err_i,
	input wire logic arr_uncorr_i,
	input wire logic arr_blank_fail_i
);
	localparam logic [15:0] FLASH_LW = FLASH_BYTES[17:2];
	localparam logic [15:0] SECTOR_LW = SECTOR_BYTES[17:2];

	logic [7:0] clkdiv;
	logic div_ok, irq_en, done_flag, access_error_flag, pviol, mass, eng_start;
	logic [1:0] vstat, sec;
	logic [7:0] prot, cmd;
	logic [2:0] step, idx;
	fcs_state_type state;
	logic eng_done, eng_err, eng_unc, eng_blank;
	logic [31:0] eng_rdata;
	logic [15:0] pword;
	logic [5:0][15:0] words;
	logic [23:0] base;
	fcs_step_type plan;
	logic wr, launch, me_start, go, bad, pv, abort, mismatch, fill, prot_all, ok;

	function automatic logic code_valid(input logic [7:0] c);
		code_valid = (c >= `FCS_C_EVALL && c <= `FCS_C_CONFIG && c != 8'h05); // [R4]
	endfunction

	function automatic logic is_pe(input logic [7:0] c);
		is_pe = (c == `FCS_C_PROG || c == `FCS_C_PONCE || c == `FCS_C_ERALL ||
			c == `FCS_C_ERBLK || c == `FCS_C_ERSEC || c == `FCS_C_UNSEC);
	endfunction

	function automatic logic addr_ok(input logic [23:0] a);
		addr_ok = (a < FLASH_BYTES);
	endfunction

	function automatic logic span_ok(input logic [23:0] a, input logic [15:0] n);
		span_ok = ({1'b0, a} + {7'h00, n, 2'h0}) <= {1'b0, FLASH_BYTES};
	endfunction

	// access error decision at launch
	function automatic logic acc_check(input logic [7:0] c, input logic [2:0] ix,
		input logic [23:0] a, input logic [15:0] w1, input logic [15:0] w2);
		logic b;
		b = !code_valid(c) || !cmd_permit_i[c[3:0]]; // [R7]
		case (c)
			`FCS_C_EVALL, `FCS_C_ERALL, `FCS_C_UNSEC: b = b || ix != `FCS_IX_0; // [R11]
			`FCS_C_EVBLK, `FCS_C_ERBLK: b = b || ix != `FCS_IX_1 || !addr_ok(a); // [R13]
			`FCS_C_EVSEC: b = b || ix != `FCS_IX_2 || !addr_ok(a) || a[1:0] != 2'h0 ||
				!span_ok(a, w2); // [R14]
			`FCS_C_RDONCE: b = b || ix != `FCS_IX_1 || w1 > `FCS_PHRASE_MAX; // [R15]
			`FCS_C_PROG: b = b || (ix != `FCS_IX_3 && ix != `FCS_IX_5) || !addr_ok(a) ||
				a[1:0] != 2'h0 || !span_ok(a, (ix == `FCS_IX_5) ? 16'h2 : 16'h1); // [R20]
			`FCS_C_PONCE: b = b || ix != `FCS_IX_5 || w1 > `FCS_PHRASE_MAX;
			`FCS_C_ERSEC: b = b || ix != `FCS_IX_1 || !addr_ok(a) || a[1:0] != 2'h0;
			`FCS_C_KEY: b = b || ix != `FCS_IX_4;
			default: b = b || ix != `FCS_IX_1;
		endcase
		acc_check = b || (is_pe(c) && !div_ok); // [R6]
	endfunction

	// array step for a command and step number
	function automatic fcs_step_type step_plan(input logic [7:0] c, input logic m,
		input logic [2:0] s, input logic [2:0] ix, input logic [23:0] a);
		fcs_step_type p;
		logic [2:0] k;
		p = '{op: OP_BLANK, ifr: 1'b0, addr: 24'h0, len: FLASH_LW, data: 32'h0,
			vfy: 1'b0, last: 1'b1};
		k = (c == `FCS_C_PONCE) ? s - 3'h1 : s;
		case (c)
			`FCS_C_EVALL, `FCS_C_EVBLK: p.last = 1'b1; // [R11]
			`FCS_C_EVSEC:
			begin
				p.addr = a;
				p.len = words[2];
			end
			`FCS_C_RDONCE:
			begin
				p.op = OP_READ;
				p.ifr = 1'b1;
				p.addr = {18'h0, words[1][2:0], s[0], 2'h0}; // [R15]
				p.last = s[0];
			end
			`FCS_C_PROG, `FCS_C_PONCE:
			begin
				p.op = k[0] ? OP_READ : OP_PROG; // [R19]
				p.vfy = k[0]; // [R21]
				p.ifr = (c == `FCS_C_PONCE);
				p.addr = p.ifr ? {18'h0, words[1][2:0], k[1], 2'h0} : a + {21'h0, k[1], 2'h0};
				p.data = k[1] ? {words[4], words[5]} : {words[2], words[3]};
				p.last = k[0] && (k[1] || ix == `FCS_IX_3);
				if (c == `FCS_C_PONCE && s == 3'h0)
				begin
					p.op = OP_BLANK; // [R16]
					p.addr = {18'h0, words[1][2:0], 3'h0};
					p.vfy = 1'b0;
					p.len = 16'h2;
					p.last = 1'b0;
				end
			end
			`FCS_C_ERALL, `FCS_C_UNSEC, `FCS_C_ERBLK, `FCS_C_ERSEC:
			begin
				p.op = s[0] ? OP_BLANK : OP_ERASE; // [R16]
				if (c == `FCS_C_ERSEC)
				begin
					p.addr = {a[23:2], 2'h0};
					p.len = SECTOR_LW;
				end
				p.last = s[0] && !m;
				if (s[1])
				begin
					p.op = s[0] ? OP_READ : OP_PROG; // [R3]
					p.vfy = s[0];
					p.addr = `FCS_CFG_LW;
					p.data = {8'hFF, `FCS_SEC_BYTE, prot, 8'hFF};
					p.last = s[0];
				end
			end
			default:
			begin
				p.op = OP_MISC;
				p.addr = {c, words[1]};
				p.data = {words[2], words[3]};
				p.len = words[4];
			end
		endcase
		step_plan = p;
	endfunction

	assign base = {words[0][7:0], words[1]};
	assign plan = step_plan(cmd, mass, step, idx, base);
	assign prot_all = prot[`FCS_B_OPEN] && prot[`FCS_B_HDIS] && prot[`FCS_B_LDIS];
	assign bad = mass ? !div_ok : acc_check(cmd, idx, base, words[1], words[2]);
	assign pv = !mass && (cmd == `FCS_C_ERALL || cmd == `FCS_C_ERBLK) && !prot_all; // [R5]
	assign abort = cmd == `FCS_C_PONCE && step == 3'h0 && eng_blank; // [R16]
	assign mismatch = plan.vfy && eng_rdata != plan.data; // [R21]
	assign fill = state == ST_RUN && eng_done && cmd == `FCS_C_RDONCE && !mass;
	assign ok = !access_error_flag && !pviol && vstat == 2'h0;

	// apb decode; launch is refused while errors are pending
	assign wr = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && (paddr_i[1:0] != 2'h0 || paddr_i > `FCS_A_SEC);
	assign launch = wr && paddr_i == `FCS_A_STATUS && pwdata_i[`FCS_B_DONE] &&
		!access_error_flag && !pviol; // [R9]
	assign me_start = dbg_ctrl_o[`FCS_D_MEREQ] && !dbg_ctrl_o[`FCS_D_RESET]; // [R1]
	assign go = state == ST_IDLE && done_flag && (me_start || launch); // [R18]
	assign irq_o = done_flag && irq_en; // [R22]

	// sequencer state machine
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			state <= ST_IDLE;
			cmd <= 8'h00;
			mass <= 1'b0;
			step <= 3'h0;
			eng_start <= 1'b0;
		end
		else
		begin
			eng_start <= 1'b0;
			case (state)
				ST_IDLE:
					if (go)
					begin
						state <= ST_CHECK;
						mass <= me_start;
						cmd <= me_start ? `FCS_C_ERALL : words[0][15:8];
					end
				ST_CHECK:
					if (bad || pv) // [R7]
						state <= ST_DONE;
					else
					begin
						state <= ST_RUN;
						step <= 3'h0;
						eng_start <= 1'b1;
					end
				ST_RUN:
					if (eng_done)
					begin
						if (plan.last || abort)
							state <= ST_DONE;
						else
						begin
							step <= step + 3'h1;
							eng_start <= 1'b1;
						end
					end
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// done flag: cleared at launch, set only when the sequence ends
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			done_flag <= 1'b1;
		else if (go)
			done_flag <= 1'b0; // [R18]
		else if (state == ST_DONE)
			done_flag <= 1'b1;
	end

	// error flags, a hardware set wins over a write-one clear
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			access_error_flag <= 1'b0;
			pviol <= 1'b0;
		end
		else
		begin
			if ((state == ST_CHECK && bad) || (state == ST_RUN && eng_done && abort))
				access_error_flag <= 1'b1; // [R6] [R7]
			else if (wr && paddr_i == `FCS_A_STATUS && pwdata_i[`FCS_B_ACCESS_ERROR_FLAG])
				access_error_flag <= 1'b0;
			if (state == ST_CHECK && !bad && pv)
				pviol <= 1'b1; // [R5]
			else if (wr && paddr_i == `FCS_A_STATUS && pwdata_i[`FCS_B_PVIOL])
				pviol <= 1'b0;
		end
	end

	// verify status bits accumulated over a command
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || go)
			vstat <= 2'h0;
		else if (state == ST_RUN && eng_done && !abort)
			vstat <= vstat | {eng_err || mismatch || (plan.op == OP_BLANK && eng_blank),
				eng_unc || (plan.op == OP_BLANK && eng_blank)}; // [R12]
	end

	// divider, interrupt enable and protection registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			clkdiv <= 8'h00;
			div_ok <= 1'b0;
			irq_en <= 1'b0;
			prot <= `FCS_PROT_RST;
		end
		else if (state == ST_DONE && mass)
		begin
			clkdiv <= 8'h00;
			div_ok <= 1'b0;
		end
		else if (wr && done_flag)
		begin
			if (paddr_i == `FCS_A_CLKDIV)
			begin
				clkdiv <= pwdata_i[7:0];
				div_ok <= 1'b1; // [R6]
			end
			if (paddr_i == `FCS_A_CONFIG)
				irq_en <= pwdata_i[`FCS_B_IRQEN];
			if (paddr_i == `FCS_A_PROT)
				prot <= pwdata_i[7:0];
		end
	end

	// security state after a mass erase, erase all, unsecure or key command; cpu hold after a debugger mass erase
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			sec <= `FCS_SEC_SECURED;
			cpu_hold_o <= 1'b0;
		end
		else if (state == ST_DONE)
		begin
			if (ok && (mass || cmd == `FCS_C_ERALL || cmd == `FCS_C_UNSEC || cmd == `FCS_C_KEY))
				sec <= `FCS_SEC_UNSEC; // [R3]
			if (mass)
				cpu_hold_o <= 1'b1; // [R3]
		end
	end

	// debug access control, request bit cleared by hardware when mass erase ends
	always_ff @(posedge mclk_i)
	begin
		if (dbg_rst_i)
			dbg_ctrl_o <= 4'h0;
		else if (dbg_wr_i)
			dbg_ctrl_o <= dbg_wdata_i;
		else if (state == ST_DONE && mass)
			dbg_ctrl_o[`FCS_D_MEREQ] <= 1'b0; // [R2]
	end

	// flash reads during a running command are flagged
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			illegal_access_o <= 1'b0;
		else
			illegal_access_o <= flash_rd_i && !done_flag; // [R8]
	end

	// read data is fetched in the setup phase
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			prdata_o <= 32'h0;
		else if (psel_i && !penable_i)
			case (paddr_i)
				`FCS_A_CLKDIV: prdata_o <= {24'h0, clkdiv};
				`FCS_A_CONFIG: prdata_o <= {24'h0, irq_en, dbg_ctrl_o[`FCS_D_MEREQ], 6'h0};
				`FCS_A_STATUS: prdata_o <= {24'h0, done_flag, 1'b0, access_error_flag, pviol, 2'h0, vstat};
				`FCS_A_PROT: prdata_o <= {24'h0, prot};
				`FCS_A_INDEX: prdata_o <= {29'h0, idx};
				`FCS_A_PARAM: prdata_o <= {16'h0, pword};
				`FCS_A_SEC: prdata_o <= {30'h0, sec};
				default: prdata_o <= 32'h0;
			endcase
	end

	fcs_param_buf #(.WORDS(6)) u_buf (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.lock_i(!done_flag),
		.idx_wr_i(wr && paddr_i == `FCS_A_INDEX),
		.data_wr_i(wr && paddr_i == `FCS_A_PARAM),
		.wdata_i(pwdata_i[15:0]),
		.fill_i(fill),
		.fill_hi_i(step[0]),
		.fill_data_i(eng_rdata),
		.idx_o(idx),
		.word_o(pword),
		.words_o(words)
	);

	fcs_array_port u_port (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(eng_start),
		.step_i(plan),
		.arr_req_o(arr_req_o),
		.arr_op_o(arr_op_o),
		.arr_ifr_o(arr_ifr_o),
		.arr_addr_o(arr_addr_o),
		.arr_len_o(arr_len_o),
		.arr_wdata_o(arr_wdata_o),
		.arr_ack_i(arr_ack_i),
		.arr_rdata_i(arr_rdata_i),
		.arr_err_i(arr_err_i),
		.arr_uncorr_i(arr_uncorr_i),
		.arr_blank_fail_i(arr_blank_fail_i),
		.done_o(eng_done),
		.rdata_o(eng_rdata),
		.err_o(eng_err),
		.uncorr_o(eng_unc),
		.blank_fail_o(eng_blank)
	);

	// checks on the sequencer
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_launch_busy: assert property (go |=> !done_flag && state == ST_CHECK) // [R18]
		else $error("launch did not start a command");
	a_done_at_end: assert property ($rose(done_flag) |-> $past(state) == ST_DONE) // [R18]
		else $error("done flag set outside the end of a command");
	a_bad_code: assert property (state == ST_CHECK && !mass && !code_valid(cmd) // [R7]
		|=> access_error_flag && state == ST_DONE ##1 done_flag)
		else $error("invalid code was not refused");
	a_no_divider: assert property (state == ST_CHECK && is_pe(cmd) && !div_ok // [R6]
		|=> access_error_flag && !arr_req_o ##1 !arr_req_o)
		else $error("command ran without a divider");
	a_erase_protect: assert property (state == ST_CHECK && !mass && !prot_all && // [R5]
		(cmd == `FCS_C_ERALL || cmd == `FCS_C_ERBLK) |=> state == ST_DONE && !arr_req_o)
		else $error("protected erase was started");
	a_evall_index: assert property (state == ST_CHECK && !mass && // [R11]
		cmd == `FCS_C_EVALL && idx != `FCS_IX_0 |=> access_error_flag)
		else $error("bad erase verify index accepted");
	a_rdonce_phrase: assert property (state == ST_CHECK && !mass && // [R15]
		cmd == `FCS_C_RDONCE && words[1] > `FCS_PHRASE_MAX |=> access_error_flag)
		else $error("bad phrase index accepted");
	a_read_illegal: assert property (flash_rd_i && !done_flag |=> illegal_access_o) // [R8]
		else $error("busy read not flagged");
	a_params_frozen: assert property (state == ST_RUN |=> $stable(idx) && $stable(words[0])) // [R23]
		else $error("parameters changed while running");
	a_blank_both: assert property (state == ST_RUN && eng_done && // [R12]
		plan.op == OP_BLANK && eng_blank && !abort |=> vstat == 2'h3)
		else $error("blank fail did not set both verify bits");
	a_mass_finish: assert property (state == ST_DONE && mass |=> !dbg_ctrl_o[0] && cpu_hold_o) // [R2]
		else $error("mass erase end not reported");
	a_irq_request: assert property ($rose(done_flag) && irq_en |-> irq_o) // [R22]
		else $error("no interrupt at command end");
	c_program: cover property (state == ST_RUN && cmd == `FCS_C_PROG && eng_done && plan.last);
	c_mass: cover property (state == ST_DONE && mass && ok);
	c_rdonce: cover property (fill && step[0]);
	c_refused: cover property (state == ST_CHECK && bad);
endmodule
`default_nettype wire

// ### testbench/fcs_array_model.sv
/*
 Behavioural flash array facing the sequencer's request port.
 Assumes each request is held until acknowledged, one answer per request.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_array_model
	import fcs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic bf_i,
	input wire logic arr_req_i,
	input wire fcs_op_type arr_op_i,
	input wire logic arr_ifr_i,
	input wire logic [23:0] arr_addr_i,
	input wire logic [31:0] arr_wdata_i,
	output logic arr_ack_o,
	output logic [31:0] arr_rdata_o,
	output logic arr_blank_fail_o
);
	logic [31:0] mem [logic [24:0]];
	int dly = 0;
	int n_req = 0;
	// outputs start at zero; ack and blank fail stay low until the first answer
	initial
	begin
		arr_ack_o = 1'b0;
		arr_rdata_o = 32'h0;
		arr_blank_fail_o = 1'b0;
	end
	// answers now and after four cycles in turn; idle data toggles every cycle
	always @(posedge mclk_i)
	begin
		arr_ack_o <= 1'b0;
		arr_rdata_o <= ~arr_rdata_o;
		if (arr_req_i && !arr_ack_o && dly > 0)
			dly <= dly - 1;
		else if (arr_req_i && !arr_ack_o)
		begin
			arr_ack_o <= 1'b1;
			n_req <= n_req + 1;
			dly <= (n_req % 2) * 4;
			arr_rdata_o <= mem.exists({arr_ifr_i, arr_addr_i}) ?
				mem[{arr_ifr_i, arr_addr_i}] : 32'hFFFFFFFF;
			arr_blank_fail_o <= bf_i && arr_op_i == OP_BLANK;
			if (arr_op_i == OP_PROG)
				mem[{arr_ifr_i, arr_addr_i}] = arr_wdata_i;
			if (arr_op_i == OP_ERASE)
				foreach (mem[k])
					if (!k[24])
						mem[k] = 32'hFFFFFFFF; // one-time field never erased
		end
	end
endmodule
`default_nettype wire

// ### testbench/flash_command_sequencer_bench.sv
/*
 Self-checking bench of the flash command sequencer.
 Assumes the array model beside it and APB with one word per register.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.svh"
module flash_command_sequencer_bench
	import fcs_pkg::*;
;
	logic mclk_i = 0, sys_rst_i = 1, dbg_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic dbg_wr_i = 0, flash_rd_i = 0, bf = 0, arr_err_i = 0, arr_uncorr_i = 0;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0;
	logic [3:0] dbg_wdata_i = 0;
	logic [15:0] cmd_permit_i = 16'hFFFF;
	logic [31:0] prdata_o, arr_wdata_o, arr_rdata_i, q, st;
	logic pready_o, pslverr_o, illegal_access_o, cpu_hold_o, irq_o, arr_req_o, arr_ifr_o, se;
	logic arr_ack_i, arr_blank_fail_i;
	logic [3:0] dbg_ctrl_o;
	logic [23:0] arr_addr_o;
	logic [15:0] arr_len_o;
	fcs_op_type arr_op_o;
	logic [15:0] pw [6];
	logic [2:0] ix [16] = '{0, 0, 1, 2, 1, 0, 3, 5, 0, 1, 1, 0, 4, 1, 1, 1};
	int bad_count = 0, n_checks = 0, cyc = 0;
	fcs_sequencer fcs_sequencer_i (.*);
	fcs_array_model fcs_array_model_i (.mclk_i(mclk_i), .bf_i(bf), .arr_req_i(arr_req_o),
		.arr_op_i(arr_op_o), .arr_ifr_i(arr_ifr_o), .arr_addr_i(arr_addr_o),
		.arr_wdata_i(arr_wdata_o), .arr_ack_o(arr_ack_i), .arr_rdata_o(arr_rdata_i),
		.arr_blank_fail_o(arr_blank_fail_i));
	// clock and hang guard
	initial
		forever #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1;
		penable_i <= 0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1)
			@(posedge mclk_i);
		q = prdata_o;
		se = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task wait_done;
		st = 0;
		for (int i = 0; i < 300 && st[7] !== 1'b1; i++)
		begin
			apb(0, `FCS_A_STATUS, 0);
			st = q;
		end
		chk("done flag", 32'h80, st & 32'h80);
	endtask
	task load(input logic [7:0] c, input logic [2:0] last);
		pw[0] = {c, 8'h00};
		for (int k = 0; k <= last; k++)
		begin
			apb(1, `FCS_A_INDEX, k);
			apb(1, `FCS_A_PARAM, {16'h0, pw[k]});
		end
	endtask
	task run(input logic [7:0] c, input logic [2:0] last);
		load(c, last);
		apb(1, `FCS_A_STATUS, 32'h80);
		wait_done();
	endtask
	task t_reset;
		apb(0, `FCS_A_STATUS, 0);
		chk("status", 32'h80, q & 32'hB3);
		apb(0, `FCS_A_SEC, 0);
		chk("security", 32'h3, q & 32'h3);
		apb(0, 8'h1C, 0);
		chk("unmapped", 32'h1, se);
		pw = '{16'h0, 16'h0100, 16'h0, 16'h0, 16'h0, 16'h0};
		run(`FCS_C_PROG, 3);
		chk("access_error_flag nodiv", 32'h20, st & 32'h20);
		chk("no request", 0, fcs_array_model_i.n_req);
		apb(1, `FCS_A_STATUS, 32'h30);
		apb(0, `FCS_A_STATUS, 0);
		chk("flags cleared", 32'h0, q & 32'h30);
		apb(1, `FCS_A_CLKDIV, 32'h13);
		$display("test reset done");
	endtask
	task t_codes;
		pw = '{16'h0, 16'h0, 16'h4, 16'h0, 16'h0, 16'h0};
		for (int c = 1; c < 16; c++)
		begin
			run(c, ix[c]);
			chk("code access_error_flag", (c == 5) ? 32'h20 : 32'h0, st & 32'h20);
			apb(1, `FCS_A_STATUS, 32'h30);
		end
		run(`FCS_C_EVALL, 1);
		chk("evall index", 32'h20, st & 32'h20);
		apb(1, `FCS_A_STATUS, 32'h30);
		pw[1] = 16'h8;
		run(`FCS_C_RDONCE, 1);
		chk("phrase index", 32'h20, st & 32'h20);
		apb(1, `FCS_A_STATUS, 32'h30);
		cmd_permit_i <= 16'hFFF7;
		run(`FCS_C_EVSEC, 2);
		chk("mode refused", 32'h20, st & 32'h20);
		cmd_permit_i <= 16'hFFFF;
		apb(1, `FCS_A_STATUS, 32'h30);
		bf = 1;
		run(`FCS_C_EVALL, 0);
		chk("blank fail", 32'h3, st & 32'h3);
		bf = 0;
		$display("test codes done");
	endtask
	task t_prog;
		apb(1, `FCS_A_CONFIG, 32'h80);
		pw = '{16'h0, 16'h0100, 16'hA5A5, 16'h5A5A, 16'h1234, 16'hABCD};
		load(`FCS_C_PROG, 5);
		apb(1, `FCS_A_STATUS, 32'h80);
		apb(0, `FCS_A_STATUS, 0);
		chk("busy done flag", 32'h0, q & 32'h80);
		chk("irq busy", 32'h0, irq_o);
		flash_rd_i <= 1;
		@(posedge mclk_i);
		flash_rd_i <= 0;
		#1 chk("illegal read", 32'h1, illegal_access_o);
		apb(1, `FCS_A_PARAM, 32'hDEAD);
		wait_done();
		chk("prog status", 32'h80, st & 32'hB3);
		chk("irq done", 32'h1, irq_o);
		chk("word 0", 32'hA5A55A5A, fcs_array_model_i.mem[25'h100]);
		chk("word 1", 32'h1234ABCD, fcs_array_model_i.mem[25'h104]);
		apb(0, `FCS_A_PARAM, 0);
		chk("param kept", 32'hABCD, q);
		apb(1, `FCS_A_CONFIG, 32'h0);
		pw = '{16'h0, 16'h2, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
		run(`FCS_C_PONCE, 5);
		pw[2:5] = '{16'h0, 16'h0, 16'h0, 16'h0};
		load(`FCS_C_RDONCE, 5);
		apb(1, `FCS_A_INDEX, 1);
		apb(1, `FCS_A_STATUS, 32'h80);
		wait_done();
		for (int k = 2; k < 6; k++)
		begin
			apb(1, `FCS_A_INDEX, k);
			apb(0, `FCS_A_PARAM, 0);
			chk("read once word", k * 32'h1111 - 32'h1111, q);
		end
		$display("test program done");
	endtask
	task t_mass;
		apb(1, `FCS_A_PROT, 32'h24);
		run(`FCS_C_ERALL, 0);
		chk("erase blocked", 32'hA5A55A5A, fcs_array_model_i.mem[25'h100]);
		chk("blocked flag", 32'h1, |(st & 32'h30));
		apb(1, `FCS_A_STATUS, 32'h30);
		apb(1, `FCS_A_PROT, 32'hA4);
		dbg_wr_i <= 1;
		dbg_wdata_i <= 4'h9;
		@(posedge mclk_i);
		dbg_wdata_i <= 4'h1;
		@(posedge mclk_i);
		dbg_wr_i <= 0;
		for (int i = 0; i < 2000 && dbg_ctrl_o[0] !== 1'b0; i++)
			@(posedge mclk_i);
		chk("request bit", 32'h0, dbg_ctrl_o[0]);
		chk("cpu hold", 32'h1, cpu_hold_o);
		apb(0, `FCS_A_SEC, 0);
		chk("unsecure", 32'h2, q & 32'h3);
		chk("sec byte", 32'hFE, fcs_array_model_i.mem[25'h40C][23:16]);
		$display("test mass erase done");
	endtask
	// main sequence
	initial
	begin
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 0;
		dbg_rst_i <= 0;
		t_reset();
		t_codes();
		t_prog();
		t_mass();
		tally_and_finish();
	end
endmodule
`default_nettype wire
